// file: inc/drasq_defs.vh
// Purpose: constants for the dram request arbiter and sequencer
// Assumes: included by its bare name
// Notes:   request codes and state codes are binary
`ifndef DRASQ_DEFS_VH
`define DRASQ_DEFS_VH
// request type codes
`define DRASQ_REQ_FILL32   4'h0
`define DRASQ_REQ_FILL16   4'h1
`define DRASQ_REQ_LW_RD    4'h2
`define DRASQ_REQ_LW_WR    4'h3
`define DRASQ_REQ_WD_WR    4'h4
`define DRASQ_REQ_HW_WR    4'h5
`define DRASQ_REQ_BY_WR    4'h6
// states
`define DRASQ_ST_IDLE      4'h0
`define DRASQ_ST_CHECK     4'h1
`define DRASQ_ST_PRE       4'h2
`define DRASQ_ST_ROW       4'h3
`define DRASQ_ST_COL       4'h4
`define DRASQ_ST_CASOFF    4'h5
`define DRASQ_ST_RCAS      4'h6
`define DRASQ_ST_RRAS      4'h7
`define DRASQ_ST_REND      4'h8
// beats per fill, minus one
`define DRASQ_BEATS32      2'h3
`define DRASQ_BEATS16      2'h1
// reset values
`define DRASQ_RAS_OFF      4'hf
`define DRASQ_CAS_OFF      2'h3
`define DRASQ_ADDR_RST     12'h000
`endif

// file: src/drasq_top.v
// Purpose: arbitrates translation and refresh requests, sequences dram cycles
// Assumes: requester waits for op_done before issuing another request
// Notes:   data alignment and parity live in the neighbouring unit
`timescale 1ns/1ps
`include "drasq_defs.vh"

module drasq_top
(
   // clock and reset
   input  wire        mclk_in,
   input  wire        reset_n_in,
   // translation requester
   input  wire        request_issue_strobe_in,
   input  wire [3:0]  request_type_code_in,
   input  wire [30:0] translated_address_bus_in,
   output reg         op_done_out,
   // refresh requester
   input  wire        refresh_req_in,
   output reg         refresh_ack_out,
   // dram pins
   output reg  [3:0]  ras_n_out,
   output reg  [1:0]  cas_n_out,
   output reg         we_n_out,
   output reg  [11:0] dram_muxed_address_out,
   // data align and parity unit
   output reg         read_capture_out,
   output reg         merge_latch_out,
   output reg         merge_write_out,
   output reg  [1:0]  merge_lane_out
);

   reg         pend_q;
   reg  [3:0]  pend_type_q;
   reg  [26:0] pend_pa_q;
   reg  [3:0]  state_q;
   reg  [3:0]  type_q;
   reg  [26:0] pa_q;
   reg  [8:0]  col_q;
   reg  [1:0]  beats_q;
   reg         rmw_wr_q;
   reg         last_mmu_q;
   reg         op_ref_q;
   reg  [3:0]  ras_pos_q;
   reg  [3:0]  open_v_q;
   reg  [11:0] open_row_q [0:3];
   integer     i;

   // decode of pending address
   wire [1:0]  pend_bank;
   wire [11:0] pend_row;
   wire        pend_paged;
   assign pend_bank  = pend_pa_q[26:25];
   assign pend_row   = {pend_pa_q[23], pend_pa_q[24], pend_pa_q[22],
                        pend_pa_q[20:12]};
   assign pend_paged = open_v_q[pend_bank] &&
                       (open_row_q[pend_bank] == pend_row);

   // current op decode
   wire [11:0] cur_row;
   wire [11:0] cur_col;
   wire        is_rmw;
   wire        is_wr;
   wire        is_word;
   wire [1:0]  cas_sel;
   assign cur_row = {pa_q[23], pa_q[24], pa_q[22], pa_q[20:12]};
   assign cur_col = {1'b0, pa_q[23], pa_q[21], col_q};
   assign is_rmw  = (type_q == `DRASQ_REQ_HW_WR) ||
                    (type_q == `DRASQ_REQ_BY_WR);
   assign is_wr   = (type_q == `DRASQ_REQ_LW_WR) ||
                    (type_q == `DRASQ_REQ_WD_WR) || rmw_wr_q;
   assign is_word = is_rmw || (type_q == `DRASQ_REQ_WD_WR);
   assign cas_sel = is_word ? (pa_q[2] ? 2'h1 : 2'h2) : 2'h0;

   // arbitration in idle, in check and at end of operation
   wire at_end;
   wire start_mmu;
   wire start_ref;
   wire go_check;
   assign at_end    = ((state_q == `DRASQ_ST_CASOFF) && (beats_q == 2'h0) &&
                       !(is_rmw && !rmw_wr_q)) ||
                      (state_q == `DRASQ_ST_REND);
   assign start_mmu = pend_q &&
                      ((state_q == `DRASQ_ST_IDLE && !refresh_req_in) ||
                       (state_q == `DRASQ_ST_CHECK) ||
                       (at_end && !(refresh_req_in && last_mmu_q)));
   assign start_ref = refresh_req_in && !start_mmu &&
                      ((state_q == `DRASQ_ST_CHECK) || at_end);
   assign go_check  = (state_q == `DRASQ_ST_IDLE) && refresh_req_in;

   // request capture, set wins over grant
   always @(posedge mclk_in)
   begin
      if (!reset_n_in)
      begin
         pend_q      <= 1'b0;
         pend_type_q <= 4'h0;
         pend_pa_q   <= 27'h0000000;
      end
      else
      begin
         if (request_issue_strobe_in)
         begin
            pend_q      <= 1'b1;
            pend_type_q <= request_type_code_in;
            pend_pa_q   <= translated_address_bus_in[26:0];
         end
         else if (start_mmu)
         begin
            pend_q <= 1'b0;
         end
      end
   end

   // sequencer
   always @(posedge mclk_in)
   begin
      if (!reset_n_in)
      begin
         state_q                <= `DRASQ_ST_IDLE;
         type_q                 <= 4'h0;
         pa_q                   <= 27'h0000000;
         col_q                  <= 9'h000;
         beats_q                <= 2'h0;
         rmw_wr_q               <= 1'b0;
         last_mmu_q             <= 1'b0;
         op_ref_q               <= 1'b0;
         ras_pos_q              <= `DRASQ_RAS_OFF;
         open_v_q               <= 4'h0;
         cas_n_out              <= `DRASQ_CAS_OFF;
         we_n_out               <= 1'b1;
         dram_muxed_address_out <= `DRASQ_ADDR_RST;
         op_done_out            <= 1'b0;
         refresh_ack_out        <= 1'b0;
         read_capture_out       <= 1'b0;
         merge_latch_out        <= 1'b0;
         merge_write_out        <= 1'b0;
         merge_lane_out         <= 2'h0;
         for (i = 0; i < 4; i = i + 1)
         begin
            open_row_q[i] <= 12'h000;
         end
      end
      else
      begin
         op_done_out      <= at_end;
         refresh_ack_out  <= start_ref;
         read_capture_out <= 1'b0;
         merge_latch_out  <= 1'b0;
         if (start_mmu)
         begin
            type_q          <= pend_type_q;
            pa_q            <= pend_pa_q;
            col_q           <= pend_pa_q[11:3];
            rmw_wr_q        <= 1'b0;
            merge_write_out <= 1'b0;
            last_mmu_q      <= 1'b1;
            op_ref_q        <= 1'b0;
            merge_lane_out  <= pend_pa_q[1:0];
            merge_latch_out <= (pend_type_q == `DRASQ_REQ_HW_WR) ||
                               (pend_type_q == `DRASQ_REQ_BY_WR);
            if (pend_type_q == `DRASQ_REQ_FILL32)
            begin
               beats_q <= `DRASQ_BEATS32;
            end
            else if (pend_type_q == `DRASQ_REQ_FILL16)
            begin
               beats_q <= `DRASQ_BEATS16;
            end
            else
            begin
               beats_q <= 2'h0;
            end
            state_q <= pend_paged ? `DRASQ_ST_COL : `DRASQ_ST_PRE;
         end
         else if (start_ref)
         begin
            last_mmu_q <= 1'b0;
            op_ref_q   <= 1'b1;
            state_q    <= `DRASQ_ST_PRE;
         end
         else if (go_check)
         begin
            state_q <= `DRASQ_ST_CHECK;
         end
         else if (at_end)
         begin
            state_q <= `DRASQ_ST_IDLE;
         end
         else
         begin
            case (state_q)
               `DRASQ_ST_PRE:
               begin
                  ras_pos_q <= `DRASQ_RAS_OFF;
                  open_v_q  <= 4'h0;
                  state_q   <= op_ref_q ? `DRASQ_ST_RCAS : `DRASQ_ST_ROW;
               end
               `DRASQ_ST_ROW:
               begin
                  dram_muxed_address_out      <= cur_row;
                  ras_pos_q[pa_q[26:25]]      <= 1'b0;
                  open_v_q[pa_q[26:25]]       <= 1'b1;
                  open_row_q[pa_q[26:25]]     <= cur_row;
                  state_q                     <= `DRASQ_ST_COL;
               end
               `DRASQ_ST_COL:
               begin
                  dram_muxed_address_out <= cur_col;
                  cas_n_out              <= cas_sel;
                  we_n_out               <= !is_wr;
                  merge_write_out        <= rmw_wr_q;
                  state_q                <= `DRASQ_ST_CASOFF;
               end
               `DRASQ_ST_CASOFF:
               begin
                  state_q          <= `DRASQ_ST_COL;
                  if (beats_q != 2'h0)
                  begin
                     beats_q <= beats_q - 2'h1;
                     if (type_q == `DRASQ_REQ_FILL32)
                     begin
                        col_q <= {col_q[8:2], col_q[1:0] + 2'h1};
                     end
                     else
                     begin
                        col_q <= {col_q[8:1], ~col_q[0]};
                     end
                  end
                  else
                  begin
                     rmw_wr_q <= 1'b1;
                  end
               end
               `DRASQ_ST_RCAS:
               begin
                  cas_n_out <= 2'h0;
                  state_q   <= `DRASQ_ST_RRAS;
               end
               `DRASQ_ST_RRAS:
               begin
                  ras_pos_q <= 4'h0;
                  state_q   <= `DRASQ_ST_REND;
               end
               `DRASQ_ST_IDLE:
               begin
                  state_q <= `DRASQ_ST_IDLE;
               end
               default:
               begin
                  state_q <= `DRASQ_ST_IDLE;
               end
            endcase
         end
         if (state_q == `DRASQ_ST_REND)
         begin
            ras_pos_q <= `DRASQ_RAS_OFF;
            cas_n_out <= `DRASQ_CAS_OFF;
         end
         // column release on every beat, the last one included
         if (state_q == `DRASQ_ST_CASOFF)
         begin
            cas_n_out        <= `DRASQ_CAS_OFF;
            we_n_out         <= 1'b1;
            merge_write_out  <= 1'b0;
            read_capture_out <= !is_wr;
         end
      end
   end

   // row strobes relaunched on the falling edge
   always @(negedge mclk_in)
   begin
      if (!reset_n_in)
      begin
         ras_n_out <= `DRASQ_RAS_OFF;
      end
      else
      begin
         ras_n_out <= ras_pos_q;
      end
   end

endmodule // drasq_top

// file: verification/drasq_top_monitor.sv
// Purpose: port checker for drasq_top
// Assumes: one clock, synchronous active-low reset
// Notes:   dram strobes are active low, the request strobe is active high
`timescale 1ns/1ps
module drasq_mon
(
   // clock and reset
   input wire logic        mclk_in,
   input wire logic        reset_n_in,
   // requesters
   input wire logic        request_issue_strobe_in,
   input wire logic [3:0]  request_type_code_in,
   input wire logic [30:0] translated_address_bus_in,
   input wire logic        op_done_out,
   input wire logic        refresh_req_in,
   input wire logic        refresh_ack_out,
   // dram and data unit
   input wire logic [3:0]  ras_n_out,
   input wire logic [1:0]  cas_n_out,
   input wire logic        we_n_out,
   input wire logic [11:0] dram_muxed_address_out,
   input wire logic        read_capture_out,
   input wire logic        merge_latch_out,
   input wire logic        merge_write_out,
   input wire logic [1:0]  merge_lane_out
);
   default clocking dcb @(posedge mclk_in); endclocking
   default disable iff (!reset_n_in);
   AST_DONE_PULSE: assert property (op_done_out |=> !op_done_out)
      else $error("done pulse too long");
   AST_REQ_DONE: assert property (request_issue_strobe_in |-> ##[3:40] op_done_out)
      else $error("request never completed");
   AST_ACK_CBR: assert property (refresh_ack_out |-> ##[0:6] (cas_n_out == 2'h0
      && ras_n_out == 4'hf)) else $error("no cas before ras after ack");
   AST_ALL_ROWS: assert property (ras_n_out == 4'h0 |-> cas_n_out == 2'h0)
      else $error("all banks strobed without cas first");
   AST_ONE_BANK: assert property (ras_n_out inside {4'hf, 4'he, 4'hd, 4'hb, 4'h7, 4'h0})
      else $error("bad row strobe pattern");
   AST_WE_CAS: assert property (!we_n_out |-> cas_n_out != 2'h3)
      else $error("write enable without column strobe");
   AST_MERGE_WE: assert property (merge_write_out |-> !we_n_out && cas_n_out != 2'h0)
      else $error("merge write not a word write");
   AST_LATCH_WR: assert property (merge_latch_out |-> ##[2:14] merge_write_out)
      else $error("merge latch without write back");
   AST_DONE_QUIET: assert property (op_done_out |-> cas_n_out == 2'h3 && we_n_out)
      else $error("strobes active at op end");
   cover property (merge_write_out);
   cover property (refresh_ack_out);
   cover property (request_issue_strobe_in && refresh_req_in);
endmodule // drasq_mon

bind drasq_top drasq_mon u_drasq_mon (.mclk_in, .reset_n_in, .request_issue_strobe_in,
   .request_type_code_in, .translated_address_bus_in, .op_done_out, .refresh_req_in,
   .refresh_ack_out, .ras_n_out, .cas_n_out, .we_n_out, .dram_muxed_address_out,
   .read_capture_out, .merge_latch_out, .merge_write_out, .merge_lane_out);

// file: verification/drasq_dram.sv
// Purpose: dram bank model, logs column and row strobes
// Assumes: sees pins at rising edge, values of the cycle just ended
// Notes:   cas with all rows idle counts as a refresh
`timescale 1ns/1ps
module drasq_dram
(
   input wire logic        mclk_in,
   input wire logic [3:0]  ras_n_in,
   input wire logic [1:0]  cas_n_in,
   input wire logic        we_n_in,
   input wire logic [11:0] addr_in
);
   logic [14:0] lg [0:7];
   logic [3:0]  ras_q = 4'hf;
   logic [1:0]  cas_q = 2'h3;
   logic [11:0] row_q = 12'h000;
   int          n = 0, opens = 0, refs = 0;
   always @(posedge mclk_in)
   begin
      ras_q <= ras_n_in;
      cas_q <= cas_n_in;
      if (cas_n_in != 2'h3 && cas_q == 2'h3)
      begin
         if (ras_n_in == 4'hf)
            refs <= refs + 1;
         else
         begin
            lg[n[2:0]] <= {we_n_in, cas_n_in, addr_in};
            n <= n + 1;
         end
      end
      if (ras_n_in != ras_q && ras_n_in != 4'hf && ras_n_in != 4'h0)
      begin
         opens <= opens + 1;
         row_q <= addr_in;
      end
   end
endmodule // drasq_dram

// file: verification/drasq_tb_top.sv
// Purpose: self-checking bench for drasq_top
// Assumes: one request outstanding at a time, except in ref_busy, which queues a second behind the first
// Notes:   expectations built from the address map
`timescale 1ns/1ps
`include "drasq_defs.vh"
module drasq_tb_top;
   logic        mclk_in = 1'b0;
   logic        reset_n_in = 1'b0;
   logic        strb = 1'b0;
   logic        rreq = 1'b0;
   logic [3:0]  typ = 4'h0;
   logic [30:0] pa = 31'h0;
   wire         done, ack, we_n, mwr, mlat, rcap;
   wire  [3:0]  ras_n;
   wire  [1:0]  cas_n, lane;
   wire  [11:0] ma;
   int          failures = 0, cmp_count = 0, acks = 0, dones = 0;
   int          rcaps = 0, mlats = 0, mwrs = 0;
   localparam [30:0] A = 31'h73aa5990;
   localparam [30:0] B = 31'h061ff028;
   drasq_top u_drasq_top (.mclk_in, .reset_n_in, .request_issue_strobe_in(strb),
      .request_type_code_in(typ), .translated_address_bus_in(pa), .op_done_out(done),
      .refresh_req_in(rreq), .refresh_ack_out(ack), .ras_n_out(ras_n), .cas_n_out(cas_n),
      .we_n_out(we_n), .dram_muxed_address_out(ma), .read_capture_out(rcap),
      .merge_latch_out(mlat), .merge_write_out(mwr), .merge_lane_out(lane));
   drasq_dram u_drasq_dram (.mclk_in, .ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n),
      .addr_in(ma));
   initial forever #50 mclk_in = ~mclk_in;
   always @(posedge mclk_in)
   begin
      if (done === 1'b1) dones <= dones + 1;
      if (ack === 1'b1) acks <= acks + 1;
      if (rcap === 1'b1) rcaps <= rcaps + 1;
      if (mlat === 1'b1) mlats <= mlats + 1;
      if (mwr === 1'b1) mwrs <= mwrs + 1;
   end
   task finish_test;
   begin
      if (failures == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   end
   endtask
   task chk(input [15:0] got, input [15:0] exp);
   begin
      cmp_count++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   end
   endtask
   task wait_for(input int d, input int ak);
      int k;
   begin
      for (k = 0; k < 80 && (dones < d || acks < ak); k++)
         @(negedge mclk_in);
      if (k == 80)
      begin
         failures++;
         $display("mismatch %0t wait limit reached", $time);
         finish_test;
      end
   end
   endtask
   task issue(input [3:0] t, input [30:0] a, input rr);
   begin
      u_drasq_dram.n = 0;
      @(negedge mclk_in);
      strb = 1'b1;
      typ = t;
      pa = a;
      rreq = rreq | rr;
      @(negedge mclk_in);
      strb = 1'b0;
      typ = ~t;
   end
   endtask
   task op(input [3:0] t, input [30:0] a, input int na, eo, input [11:0] m,
           input [3:0] w, input [1:0] cs);
      int i, nr, rc, ml, mw, rmw;
      logic [11:0] c, e;
   begin
      c = {1'b0, a[23], a[21], a[11:3]};
      nr = 0;
      rc = rcaps;
      ml = mlats;
      mw = mwrs;
      rmw = (t == `DRASQ_REQ_HW_WR) || (t == `DRASQ_REQ_BY_WR);
      u_drasq_dram.opens = 0;
      issue(t, a, 1'b0);
      wait_for(dones + 1, acks);
      chk(16'(u_drasq_dram.n), 16'(na));
      for (i = 0; i < na; i++)
      begin
         nr += int'(w[i]);
         e = (c & ~m) | ((c + 12'(i)) & m);
         chk(16'(u_drasq_dram.lg[i]), {1'b0, w[i], cs, e});
      end
      chk(16'(u_drasq_dram.opens), 16'(eo));
      if (eo) chk(16'(u_drasq_dram.row_q), {4'h0, a[23], a[24], a[22], a[20:12]});
      chk(16'(ras_n), {12'h000, ~(4'h1 << a[26:25])});
      chk(16'(rcaps - rc), 16'(nr));
      chk(16'(mlats - ml), 16'(rmw));
      chk(16'(mwrs - mw), 16'(rmw));
      chk(16'(lane), 16'(a[1:0]));
   end
   endtask
   task ref_idle;
      int r, d;
   begin
      r = u_drasq_dram.refs;
      d = dones;
      u_drasq_dram.n = 0;
      @(negedge mclk_in);
      rreq = 1'b1;
      wait_for(d, acks + 1);
      rreq = 1'b0;
      wait_for(d + 1, acks);
      chk(16'(u_drasq_dram.refs), 16'(r + 1));
      chk(16'(u_drasq_dram.n), 16'h0);
      chk(16'(ras_n), 16'hf);
   end
   endtask
   task ref_busy;
      int r, d, a;
   begin
      r = u_drasq_dram.refs;
      d = dones;
      a = acks;
      issue(`DRASQ_REQ_LW_RD, A, 1'b0);
      rreq = 1'b1;
      issue(`DRASQ_REQ_LW_RD, A, 1'b0);
      wait_for(d + 1, a + 1);
      rreq = 1'b0;
      wait_for(d + 2, a + 1);
      chk(16'(u_drasq_dram.refs), 16'(r + 1));
      chk(16'(u_drasq_dram.n), 16'h1);
      wait_for(d + 3, a + 1);
      chk(16'(u_drasq_dram.n), 16'h2);
      chk(16'(acks), 16'(a + 1));
   end
   endtask
   task ref_mmu;
      int r, d, a;
   begin
      r = u_drasq_dram.refs;
      d = dones;
      a = acks;
      issue(`DRASQ_REQ_LW_WR, A, 1'b1);
      wait_for(d + 1, a);
      chk(16'(u_drasq_dram.refs), 16'(r));
      chk(16'(u_drasq_dram.n), 16'h1);
      wait_for(d + 1, a + 1);
      rreq = 1'b0;
      wait_for(d + 2, a + 1);
      chk(16'(u_drasq_dram.refs), 16'(r + 1));
   end
   endtask
   initial
   begin
      repeat (10) @(negedge mclk_in);
      reset_n_in = 1'b1;
      op(`DRASQ_REQ_FILL32, A, 4, 1, 12'h3, 4'hf, 2'h0);
      op(`DRASQ_REQ_FILL16, A + 8, 2, 0, 12'h1, 4'hf, 2'h0);
      op(`DRASQ_REQ_LW_RD, A, 1, 0, 12'h0, 4'hf, 2'h0);
      op(`DRASQ_REQ_LW_WR, A, 1, 0, 12'h0, 4'h0, 2'h0);
      op(`DRASQ_REQ_WD_WR, A + 4, 1, 0, 12'h0, 4'h0, 2'h1);
      op(`DRASQ_REQ_WD_WR, A, 1, 0, 12'h0, 4'h0, 2'h2);
      op(`DRASQ_REQ_HW_WR, A + 6, 2, 0, 12'h0, 4'h1, 2'h1);
      op(`DRASQ_REQ_BY_WR, A + 1, 2, 0, 12'h0, 4'h1, 2'h2);
      op(`DRASQ_REQ_LW_RD, B, 1, 1, 12'h0, 4'hf, 2'h0);
      ref_idle;
      ref_busy;
      ref_mmu;
      finish_test;
   end
endmodule // drasq_tb_top
